// file: shared/srw_pkg.sv
package srw_pkg;
    // Reference clock, Hz
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 100;
    // Prescaler: one tick per millisecond
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYC = (CLK_HZ / 1000) * TICK_MS;
    localparam int unsigned PRE_W = 14;
    // Documented times
    localparam int unsigned RST_PULSE_MS = 200;
    localparam int unsigned RST_MIN_MS = 140;
    localparam int unsigned WD_PERIOD_MS = 1600;
    localparam int unsigned KICK_MIN_NS = 50;
    // Least kick width in cycles, rounded up, never below one
    localparam int unsigned KICK_MIN_CYC_RAW = (KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned KICK_MIN_CYC = (KICK_MIN_CYC_RAW < 1) ? 1 : KICK_MIN_CYC_RAW;
    localparam int unsigned MS_W = 11;
    localparam logic [1:0] SYNC_RST = 2'h0;
endpackage : srw_pkg

// file: shared/srw_kick_if.sv
interface srw_kick_if;
    logic kick_event;
    logic kick_float;
    modport src (output kick_event, output kick_float);
    modport dst (input  kick_event, input  kick_float);
endinterface : srw_kick_if

// file: verilog/srw_kick_detect.sv
module srw_kick_detect
    import srw_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // Kick pin
    input  wire logic watchdog_kick_in_i,
    input  wire logic watchdog_kick_float_i,
    // To the watchdog
    srw_kick_if.src   kick
);
    logic [1:0] sync_q;
    logic       last_q;
    logic       flt_q;
    logic       event_q;

    // Only the second stage feeds the edge compare
    wire  edge_w = sync_q[1] ^ last_q;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sync_q  <= SYNC_RST;
            last_q  <= 1'b0;
            flt_q   <= 1'b1;
            event_q <= 1'b0;
        end else begin
            sync_q  <= {sync_q[0], watchdog_kick_in_i};
            last_q  <= sync_q[1];
            flt_q   <= watchdog_kick_float_i;
            event_q <= edge_w & ~flt_q;
        end
    end

    assign kick.kick_event = event_q;
    assign kick.kick_float = flt_q;

    // Back-to-back pin edges give back-to-back events, so only check that none appears without an edge
    AST_ONE_EVENT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !edge_w |=> !event_q) else $error("kick event without a synchronised edge");
endmodule : srw_kick_detect

// file: verilog/srw_supervisor.sv
// Operation
// - Reset held about 200ms after supply-low clears.
// - Active-high reset is always the inverse of active-low reset.
// - Reset asserts immediately when supply-low becomes true.
// - Brownout during a running reset keeps pulse at least 140ms.
// - Manual reset low asserts reset; every pulse lasts at least 140ms.
// - No kick activity for 1.6s drives watchdog expired low.
// - Expired output stays low until next kick activity or until reset is asserted.
// - Floating kick input keeps watchdog counter cleared and idle.
// - Watchdog disabled and cleared while reset asserted.
// - After reset, a kick edge of 50ns starts a fresh 1.6s countdown.
// - Each further kick edge restarts the full countdown.
// - Supply-low forces watchdog expired low regardless of counter.
// - Supply-low clearing releases watchdog expired at once.
// - Power-fail flag low while comparator reports input below reference.
// - Manual reset release holds reset a further 200ms.
// - Watchdog expiry alone never asserts reset.
module srw_supervisor
    import srw_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC,
    parameter int unsigned RST_MS      = RST_PULSE_MS,
    parameter int unsigned WD_MS       = WD_PERIOD_MS
) (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // Supply and comparator, already digitised
    input  wire logic supply_low_i,
    input  wire logic power_fail_sense_i,
    // Processor side
    input  wire logic manual_reset_n_i,
    input  wire logic watchdog_kick_in_i,
    input  wire logic watchdog_kick_float_i,
    // Outputs
    output logic      reset_n_o,
    output logic      reset_o,
    output logic      watchdog_expired_n_o,
    output logic      power_fail_flag_n_o
);
    typedef enum logic [1:0] {
        SRW_HOLD    = 2'b00,
        SRW_STRETCH = 2'b01,
        SRW_RUN     = 2'b10
    } srw_state_t;

    localparam logic [MS_W-1:0] RST_MS_L = MS_W'(RST_MS);
    localparam logic [MS_W-1:0] WD_MS_L  = MS_W'(WD_MS);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

    srw_kick_if kick ();

    srw_kick_detect u_kick (
        .ref_clk_i             (ref_clk_i),
        .rst_i                 (rst_i),
        .watchdog_kick_in_i    (watchdog_kick_in_i),
        .watchdog_kick_float_i (watchdog_kick_float_i),
        .kick                  (kick.src)
    );

    srw_state_t       st_q, st_d;
    logic [PRE_W-1:0] pre_q;
    logic [MS_W-1:0]  rst_cnt_q, rst_cnt_d;
    logic [MS_W-1:0]  wd_cnt_q, wd_cnt_d;
    logic             wd_exp_q, wd_exp_d;
    logic             reset_n_q, reset_q, wdo_q, pfo_q;

    // Free-running prescaler gives a millisecond tick
    wire tick_w      = (pre_q == PRE_LAST);
    // Any low-side cause holds reset; expiry is not among them
    wire cause_w     = supply_low_i | ~manual_reset_n_i;
    wire rst_done_w  = (rst_cnt_q >= RST_MS_L);
    wire wd_clear_w  = (st_d != SRW_RUN) | kick.kick_float | kick.kick_event;
    wire wd_done_w   = (wd_cnt_q >= WD_MS_L - MS_W'(1));

    always_comb begin
        st_d      = st_q;
        rst_cnt_d = rst_cnt_q;
        case (st_q)
            SRW_HOLD: begin
                rst_cnt_d = '0;
                if (!cause_w) begin
                    st_d = SRW_STRETCH;
                end
            end
            SRW_STRETCH: begin
                // Brownout or new press restarts the full stretch, so 140ms is always met
                if (cause_w) begin
                    st_d = SRW_HOLD;
                end else if (rst_done_w) begin
                    st_d = SRW_RUN;
                end else if (tick_w) begin
                    rst_cnt_d = rst_cnt_q + MS_W'(1);
                end
            end
            SRW_RUN: begin
                if (cause_w) begin
                    st_d = SRW_HOLD;
                end
            end
            default: begin
                st_d = SRW_HOLD;
            end
        endcase
    end

    always_comb begin
        wd_cnt_d = wd_cnt_q;
        wd_exp_d = wd_exp_q;
        if (wd_clear_w) begin
            wd_cnt_d = '0;
            if (kick.kick_event || st_d != SRW_RUN) begin
                wd_exp_d = 1'b0;
            end
        end else if (tick_w && !wd_exp_q) begin
            if (wd_done_w) begin
                wd_exp_d = 1'b1;
            end else begin
                wd_cnt_d = wd_cnt_q + MS_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_q      <= SRW_HOLD;
            pre_q     <= '0;
            rst_cnt_q <= '0;
            wd_cnt_q  <= '0;
            wd_exp_q  <= 1'b0;
        end else begin
            st_q      <= st_d;
            pre_q     <= tick_w ? '0 : pre_q + PRE_W'(1);
            rst_cnt_q <= rst_cnt_d;
            wd_cnt_q  <= wd_cnt_d;
            wd_exp_q  <= wd_exp_d;
        end
    end

    // Outputs registered from next-state so supply-low acts on the next edge
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reset_n_q <= 1'b0;
            reset_q   <= 1'b1;
            wdo_q     <= 1'b0;
            pfo_q     <= 1'b1;
        end else begin
            reset_n_q <= (st_d == SRW_RUN);
            reset_q   <= (st_d != SRW_RUN);
            wdo_q     <= ~(supply_low_i | wd_exp_d);
            pfo_q     <= ~power_fail_sense_i;
        end
    end

    assign reset_n_o            = reset_n_q;
    assign reset_o              = reset_q;
    assign watchdog_expired_n_o = wdo_q;
    assign power_fail_flag_n_o  = pfo_q;

    sequence s_cause_gone;
        !cause_w;
    endsequence

    AST_INVERSE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reset_o == !reset_n_o) else $error("reset outputs not complementary");
    AST_SUPPLY_RESET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        supply_low_i |=> !reset_n_o) else $error("reset not asserted on supply low");
    AST_MR_RESET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !manual_reset_n_i |=> !reset_n_o) else $error("reset not asserted on manual reset");
    AST_STRETCH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st_q == SRW_HOLD) ##1 s_cause_gone |=> !reset_n_o [*8]) else $error("reset released too early");
    AST_WDO_SUPPLY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        supply_low_i |=> !watchdog_expired_n_o) else $error("expired output high in supply low");
    AST_WDO_RELEASE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $fell(supply_low_i) && !wd_exp_d |=> watchdog_expired_n_o) else $error("expired output slow");
    AST_WD_RESET_CLR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !reset_n_o |-> wd_cnt_q == '0 || st_q == SRW_RUN) else $error("watchdog counts in reset");
    AST_WD_FLOAT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        kick.kick_float |=> wd_cnt_q == '0) else $error("watchdog counts while floating");
    AST_PFO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        power_fail_sense_i |=> !power_fail_flag_n_o) else $error("power fail flag missed");
    AST_NO_WD_RESET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(wd_exp_q) && !cause_w && st_q == SRW_RUN |=> reset_n_o) else $error("expiry caused reset");
endmodule : srw_supervisor

// file: tb/srw_cpu_model.sv
module srw_cpu_model (
    // Clock
    input  wire logic        ref_clk_i,
    // Control from the bench
    input  wire logic        float_en_i,
    input  wire logic        kick_req_i,
    input  wire logic [15:0] period_i,
    // Processor pins
    output logic             watchdog_kick_in_o,
    output logic             watchdog_kick_float_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic        level_q = 1'b0;
    logic [15:0] cnt_q   = 16'h0;
    wire         kick_due = kick_req_i || (period_i != 16'h0 && cnt_q + 16'h1 >= period_i);

    always @(posedge ref_clk_i) begin
        cnt_q <= kick_due ? 16'h0 : cnt_q + 16'h1;
        if (kick_due && !float_en_i) begin
            level_q <= ~level_q;
        end
    end

    // A released pin has no keeper, so it shows the opposite of the last driven level
    assign watchdog_kick_in_o    = float_en_i ? ~level_q : level_q;
    assign watchdog_kick_float_o = float_en_i;
endmodule : srw_cpu_model

// file: tb/test_supervisor_reset_watchdog.sv
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module test_supervisor_reset_watchdog;
    timeunit 1ns;
    timeprecision 100ps;

    // Short counts so the run stays brief: 1 tick = 10 cycles
    localparam int unsigned TK = 10;
    localparam int unsigned RMS = 20;
    localparam int unsigned WMS = 40;

    logic        ref_clk_i          = 1'b0;
    logic        rst_i              = 1'b1;
    logic        supply_low_i       = 1'b0;
    logic        power_fail_sense_i = 1'b0;
    logic        manual_reset_n_i   = 1'b1;
    logic        float_en           = 1'b0;
    logic        kick_req           = 1'b0;
    logic [15:0] period             = 16'h12c;
    int          fail_count         = 0;
    int          n_tests            = 0;
    int          cyc                = 0;
    wire         kick_pin;
    wire         kick_float;
    wire         reset_n;
    wire         reset_hi;
    wire         wdo_n;
    wire         pf_n;

    srw_supervisor #(.TICK_CYCLES(TK), .RST_MS(RMS), .WD_MS(WMS)) u_srw_supervisor (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .supply_low_i(supply_low_i),
        .power_fail_sense_i(power_fail_sense_i), .manual_reset_n_i(manual_reset_n_i),
        .watchdog_kick_in_i(kick_pin), .watchdog_kick_float_i(kick_float), .reset_n_o(reset_n),
        .reset_o(reset_hi), .watchdog_expired_n_o(wdo_n), .power_fail_flag_n_o(pf_n));

    srw_cpu_model u_srw_cpu_model (
        .ref_clk_i(ref_clk_i), .float_en_i(float_en), .kick_req_i(kick_req), .period_i(period),
        .watchdog_kick_in_o(kick_pin), .watchdog_kick_float_o(kick_float));

    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #10;
    endtask : step

    task automatic kick;
        kick_req = 1'b1;
        step(1);
        kick_req = 1'b0;
        step(1);
    endtask : kick

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    task automatic power_up;
        supply_low_i = 1'b1;
        step(20);
        `CHK(wdo_n, 1'b0)
        `CHK(reset_n, 1'b0)
        supply_low_i = 1'b0;
        step(2);
        `CHK(wdo_n, 1'b1)
        // Brownout while the stretch is still running
        step(98);
        supply_low_i = 1'b1;
        step(1);
        supply_low_i = 1'b0;
        step(138);
        `CHK(reset_n, 1'b0)
        step(52);
        `CHK(reset_n, 1'b0)
        step(30);
        `CHK(reset_n, 1'b1)
        `CHK(reset_hi, ~reset_n)
    endtask : power_up

    task automatic power_down;
        supply_low_i = 1'b1;
        step(2);
        `CHK(reset_n, 1'b0)
        `CHK(reset_hi, 1'b1)
        `CHK(wdo_n, 1'b0)
        supply_low_i = 1'b0;
        step(220);
        `CHK(reset_n, 1'b1)
    endtask : power_down

    task automatic manual_pulse;
        manual_reset_n_i = 1'b0;
        step(2);
        `CHK(reset_n, 1'b0)
        step(3);
        manual_reset_n_i = 1'b1;
        step(190);
        `CHK(reset_n, 1'b0)
        step(30);
        `CHK(reset_n, 1'b1)
    endtask : manual_pulse

    task automatic expiry;
        period = 16'h0;
        kick();
        step(389);
        `CHK(wdo_n, 1'b1)
        step(35);
        `CHK(wdo_n, 1'b0)
        `CHK(reset_n, 1'b1)
        step(100);
        `CHK(wdo_n, 1'b0)
        kick();
        step(8);
        `CHK(wdo_n, 1'b1)
    endtask : expiry

    task automatic reset_holds_wd;
        manual_reset_n_i = 1'b0;
        step(700);
        manual_reset_n_i = 1'b1;
        step(220);
        `CHK(wdo_n, 1'b1)
        kick();
    endtask : reset_holds_wd

    task automatic float_hold;
        kick();
        float_en = 1'b1;
        step(600);
        `CHK(wdo_n, 1'b1)
        float_en = 1'b0;
        step(300);
        `CHK(wdo_n, 1'b1)
        step(150);
        `CHK(wdo_n, 1'b0)
        kick();
        step(8);
        `CHK(wdo_n, 1'b1)
    endtask : float_hold

    task automatic refresh;
        period = 16'h12c;
        step(1300);
        `CHK(wdo_n, 1'b1)
    endtask : refresh

    task automatic power_fail;
        power_fail_sense_i = 1'b1;
        step(2);
        `CHK(pf_n, 1'b0)
        power_fail_sense_i = 1'b0;
        step(2);
        `CHK(pf_n, 1'b1)
    endtask : power_fail

    // Ceiling well above the roughly 4600 cycles that the scenarios need
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 10000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        step(4);
        rst_i = 1'b0;
        power_up();
        power_down();
        manual_pulse();
        expiry();
        reset_holds_wd();
        float_hold();
        refresh();
        power_fail();
        report_and_stop();
    end
endmodule : test_supervisor_reset_watchdog
